// ---- core/wcr_top.sv ----
/*
 * Countdown watchdog with low-power handling and APB access.
 * Assumes halt, interrupt and option inputs come from logic on CLK.
 */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "wcr_defs.svh"

module wcr_top
    import wcr_pkg::*;
#(
    parameter int PRESC_DIV = `WCR_PRESC_DIV
)
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        HALT_EXEC,
    input  wire logic        OSC_INTERRUPT_ENABLE,
    input  wire logic        HALT_RESET_OPTION,
    input  wire logic        HW_WATCHDOG_OPTION,
    input  wire logic        WAKE_DELAY_LONG,
    input  wire logic        OSC_IRQ,
    input  wire logic        EXT_IRQ,
    output logic             WDG_RESET_N,
    output logic             WDG_ACTIVE
);

    localparam int PULSE_CYC = `WCR_PULSE_CYC;
    localparam logic [9:0] PULSE_LOAD = 10'(PULSE_CYC);

    wcr_state_e  state;
    wcr_state_e  next_state;
    wcr_cnt_t    counter_value;
    logic        watchdog_activate;
    logic        tick;
    logic        active;
    logic        wr_access;
    logic        rd_setup;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        wr_ctrl;
    logic        dec_en;
    logic        roll_fire;
    logic        soft_fire;
    logic        halt_fire;
    logic        fire;
    logic [12:0] wake_cnt;
    logic [9:0]  pulse_cnt;
    logic [7:0]  ctrl_view;
    logic [7:0]  stat_view;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    wcr_prescaler #(
        .DIV (PRESC_DIV)
    ) u_presc (
        .CLK  (CLK),
        .RST  (RST),
        .TICK (tick)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign hit_ctrl  = (PADDR == `WCR_ADDR_CTRL);
    assign hit_stat  = (PADDR == `WCR_ADDR_STAT);
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign rd_setup  = PSEL && !PENABLE && !PWRITE;
    assign wr_ctrl   = wr_access && hit_ctrl;
    assign PREADY    = 1'b1;
    assign PSLVERR   = PSEL && PENABLE && !(hit_ctrl || hit_stat);

    // ------------------------------------------------------------
    // Activation
    // ------------------------------------------------------------
    // hardware option forces active
    assign active = watchdog_activate || HW_WATCHDOG_OPTION;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            watchdog_activate <= 1'b0;
        end
        else if (wr_ctrl && PWDATA[`WCR_ACT_BIT])
        begin
            watchdog_activate <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // runs regardless of activation
    // slow and wait are not inputs
    assign dec_en = tick
                    && (state == WCR_RUN || state == WCR_HALT_DEC);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            counter_value <= 7'(`WCR_CTRL_RST);
        end
        else if (wr_ctrl)
        begin
            counter_value <= PWDATA[6:0];
        end
        else if (dec_en)
        begin
            counter_value <= counter_value - 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Reset causes
    // ------------------------------------------------------------
    // roll from 40h to 3Fh
    assign roll_fire = active && dec_en && (state == WCR_RUN)
                       && (counter_value == `WCR_CNT_ROLL)
                       && !wr_ctrl;

    assign soft_fire = wr_ctrl
                       && (PWDATA[`WCR_ACT_BIT] || active)
                       && !PWDATA[`WCR_TOP_BIT];

    assign halt_fire = HALT_EXEC && (state == WCR_RUN)
                       && !OSC_INTERRUPT_ENABLE && HALT_RESET_OPTION;

    assign fire = roll_fire || soft_fire || halt_fire;

    // ------------------------------------------------------------
    // Reset pulse
    // ------------------------------------------------------------
    // low for about 30 us
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            pulse_cnt <= 10'h000;
        end
        else if (fire && pulse_cnt == 10'h000)
        begin
            pulse_cnt <= PULSE_LOAD;
        end
        else if (pulse_cnt != 10'h000)
        begin
            pulse_cnt <= pulse_cnt - 10'h001;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            WDG_RESET_N <= 1'b1;
        end
        else
        begin
            WDG_RESET_N <= !(fire || pulse_cnt > 10'h001);
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            WDG_ACTIVE <= 1'b0;
        end
        else
        begin
            WDG_ACTIVE <= active;
        end
    end

    // ------------------------------------------------------------
    // Power mode sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        unique case (state)
            WCR_BOOT:
            begin
                next_state = WCR_WAKE;
            end
            WCR_RUN:
            begin
                if (HALT_EXEC && OSC_INTERRUPT_ENABLE)
                begin
                    next_state = WCR_ACT_HALT;
                end
                else if (HALT_EXEC && !HALT_RESET_OPTION)
                begin
                    next_state = WCR_HALT_DEC;
                end
            end
            WCR_HALT_DEC:
            begin
                if (EXT_IRQ)
                begin
                    next_state = WCR_WAKE;
                end
                else if (tick)
                begin
                    next_state = WCR_FROZEN;
                end
            end
            WCR_FROZEN:
            begin
                if (EXT_IRQ)
                begin
                    next_state = WCR_WAKE;
                end
            end
            WCR_ACT_HALT:
            begin
                if (OSC_IRQ || EXT_IRQ)
                begin
                    next_state = WCR_RUN;
                end
            end
            WCR_WAKE:
            begin
                if (wake_cnt == 13'd1)
                begin
                    next_state = WCR_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= WCR_BOOT;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Wake delay
    // ------------------------------------------------------------
    // 256 or 4096 clocks
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            wake_cnt <= 13'd0;
        end
        else if (next_state == WCR_WAKE && state != WCR_WAKE)
        begin
            wake_cnt <= WAKE_DELAY_LONG ? `WCR_WAKE_LONG
                                        : `WCR_WAKE_SHORT;
        end
        else if (state == WCR_WAKE && wake_cnt != 13'd0)
        begin
            wake_cnt <= wake_cnt - 13'd1;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    assign ctrl_view = {watchdog_activate, counter_value};

    always_comb
    begin
        stat_view = 8'h00;
        stat_view[`WCR_ST_ACTIVE]    = active;
        stat_view[`WCR_ST_RESETTING] = (pulse_cnt != 10'h000);
        stat_view[`WCR_ST_FROZEN]    = (state == WCR_FROZEN);
        stat_view[`WCR_ST_ACT_HALT]  = (state == WCR_ACT_HALT);
        stat_view[`WCR_ST_WAKING]    = (state == WCR_WAKE)
                                       || (state == WCR_BOOT);
        stat_view[`WCR_ST_HALT_DEC]  = (state == WCR_HALT_DEC);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            PRDATA <= 32'h00000000;
        end
        else if (rd_setup)
        begin
            if (hit_ctrl)
            begin
                PRDATA <= {24'h000000, ctrl_view};
            end
            else if (hit_stat)
            begin
                PRDATA <= {24'h000000, stat_view};
            end
            else
            begin
                PRDATA <= 32'h00000000;
            end
        end
    end

endmodule : wcr_top

// ---- core/wcr_defs.svh ----
/*
 * Offsets, field positions, reset values and timing counts of the
 * countdown watchdog. Assumes a 20 MHz block clock.
 */
`ifndef WCR_DEFS_SVH
`define WCR_DEFS_SVH

// ----------------------------------------------------------------
// Register map (index, byte address is four times it)
// ----------------------------------------------------------------
`define WCR_IDX_CTRL     12'h02A
`define WCR_IDX_STAT     12'h02E
`define WCR_ADDR_CTRL    (`WCR_IDX_CTRL << 2)
`define WCR_ADDR_STAT    (`WCR_IDX_STAT << 2)

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define WCR_ACT_BIT      7
`define WCR_TOP_BIT      6
`define WCR_CTRL_RST     8'h7F
`define WCR_CNT_ROLL     7'h40
`define WCR_ST_ACTIVE    0
`define WCR_ST_RESETTING 1
`define WCR_ST_FROZEN    2
`define WCR_ST_ACT_HALT  3
`define WCR_ST_WAKING    4
`define WCR_ST_HALT_DEC  5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WCR_PRESC_DIV    16384
`define WCR_WAKE_SHORT   13'd256
`define WCR_WAKE_LONG    13'd4096
`define WCR_CLK_NS       50
`define WCR_PULSE_NS     30000
`define WCR_PULSE_CYC    \
    ((`WCR_PULSE_NS + `WCR_CLK_NS - 1) / `WCR_CLK_NS)

`endif

// ---- core/wcr_pkg.sv ----
/*
 * Types of the countdown watchdog.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wcr_pkg;

    typedef enum logic [2:0] {
        WCR_BOOT,
        WCR_RUN,
        WCR_HALT_DEC,
        WCR_FROZEN,
        WCR_ACT_HALT,
        WCR_WAKE
    } wcr_state_e;

    typedef logic [6:0] wcr_cnt_t;

endpackage : wcr_pkg

// ---- core/wcr_prescaler.sv ----
/*
 * Free-running divider giving one tick per DIV clocks.
 * Assumes a synchronous clock and active-high asynchronous reset.
 */
`timescale 1ns/1ns

module wcr_prescaler
    import wcr_pkg::*;
#(
    parameter int DIV = 16384
)
(
    input  wire logic CLK,
    input  wire logic RST,
    output logic      TICK
);

    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] phase;

    // ------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            phase <= '0;
            TICK  <= 1'b0;
        end
        else
        begin
            TICK  <= (phase == LAST);
            phase <= (phase == LAST) ? '0 : phase + 1'b1;
        end
    end

endmodule : wcr_prescaler

// ---- tb/wcr_checker.sv ----
/*
 * Port assertions of the countdown watchdog.
 * Assumes it is bound into wcr_top.
 */
`timescale 1ns/1ns
`include "wcr_defs.svh"

module wcr_checker
    import wcr_pkg::*;
#(
    parameter int PRESC_DIV = 16384
)
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        HALT_EXEC,
    input wire logic        OSC_INTERRUPT_ENABLE,
    input wire logic        HALT_RESET_OPTION,
    input wire logic        HW_WATCHDOG_OPTION,
    input wire logic        WDG_RESET_N,
    input wire logic        WDG_ACTIVE
);

    logic       wr_ctrl;
    logic [9:0] low_cnt;

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    assign wr_ctrl = PSEL && PENABLE && PWRITE && PADDR == `WCR_ADDR_CTRL;

    // Cycles of the running reset pulse
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            low_cnt <= 10'h000;
        else if (WDG_RESET_N)
            low_cnt <= 10'h000;
        else
            low_cnt <= low_cnt + 10'h001;
    end

    AST_PULSE_LEN: assert property ($rose(WDG_RESET_N) |->
        low_cnt == `WCR_PULSE_CYC) else $error("pulse length wrong");
    AST_PULSE_HOLD: assert property ($fell(WDG_RESET_N) |->
        ##1 !WDG_RESET_N [*8]) else $error("pulse ended early");
    AST_SW_RESET: assert property (wr_ctrl && PWDATA[7] &&
        !PWDATA[6] && WDG_RESET_N |=> !WDG_RESET_N)
        else $error("no software reset");
    AST_HALT_RESET: assert property (HALT_EXEC &&
        !OSC_INTERRUPT_ENABLE && HALT_RESET_OPTION && WDG_RESET_N
        |=> !WDG_RESET_N) else $error("no halt reset");
    AST_HALT_QUIET: assert property (HALT_EXEC && WDG_RESET_N &&
        (OSC_INTERRUPT_ENABLE || !HALT_RESET_OPTION)
        |=> WDG_RESET_N [*8]) else $error("reset after quiet halt");
    AST_FIRE_CAUSE: assert property ($fell(WDG_RESET_N) |->
        WDG_ACTIVE || $past(wr_ctrl && PWDATA[7]) ||
        $past(HALT_EXEC && HALT_RESET_OPTION && !OSC_INTERRUPT_ENABLE))
        else $error("reset without cause");
    AST_ACT_STICKY: assert property (WDG_ACTIVE &&
        !HW_WATCHDOG_OPTION && !$past(HW_WATCHDOG_OPTION)
        |=> WDG_ACTIVE) else $error("activation lost");
    AST_HW_ACTIVE: assert property ($past(HW_WATCHDOG_OPTION) &&
        !$past(RST) |-> WDG_ACTIVE) else $error("hardware option ignored");

endmodule : wcr_checker

bind wcr_top wcr_checker #(.PRESC_DIV(PRESC_DIV)) i_checker (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .HALT_EXEC(HALT_EXEC), .OSC_INTERRUPT_ENABLE(OSC_INTERRUPT_ENABLE),
    .HALT_RESET_OPTION(HALT_RESET_OPTION),
    .HW_WATCHDOG_OPTION(HW_WATCHDOG_OPTION),
    .WDG_RESET_N(WDG_RESET_N), .WDG_ACTIVE(WDG_ACTIVE)
);

// ---- tb/wcr_top_test.sv ----
/*
 * Self-checking bench of the countdown watchdog over APB.
 * Assumes wcr_top with a 16-clock prescaler.
 */
`timescale 1ns/1ns
`include "wcr_defs.svh"

module wcr_top_test
    import wcr_pkg::*;
;

    localparam logic [11:0] CTRL = `WCR_ADDR_CTRL;
    localparam logic [11:0] STAT = `WCR_ADDR_STAT;

    logic        clk, rst, psel, penable, pwrite, halt, osc_interrupt_enable, hro, hwo;
    logic        wdl, osc_irq, ext_irq, pready, pslverr, rst_n_out;
    logic        active, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_val, first;
    int          n_fail, total_checks, waited, i;

    wcr_top #(.PRESC_DIV(16)) i_dut (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .HALT_EXEC(halt),
        .OSC_INTERRUPT_ENABLE(osc_interrupt_enable), .HALT_RESET_OPTION(hro),
        .HW_WATCHDOG_OPTION(hwo), .WAKE_DELAY_LONG(wdl),
        .OSC_IRQ(osc_irq), .EXT_IRQ(ext_irq), .WDG_RESET_N(rst_n_out),
        .WDG_ACTIVE(active)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        // Idle edge after a transfer that just ended
        if (psel === 1'b1)
            @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd_val = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic look(input string what, input logic exp);
        @(negedge clk);
        chk(what, {31'h0, rst_n_out}, {31'h0, exp});
        @(posedge clk);
    endtask : look

    task automatic wait_fire(input int lim);
        waited = 0;
        while (rst_n_out !== 1'b0 && waited < lim)
        begin
            @(negedge clk);
            waited++;
        end
        chk("fire", {31'h0, rst_n_out}, 32'h0);
        @(posedge clk);
    endtask : wait_fire

    task automatic pulse_halt();
        halt <= 1'b1;
        cyc(1);
        halt <= 1'b0;
    endtask : pulse_halt

    task automatic step(input string what);
        apb(0, CTRL, 32'h0);
        first = rd_val;
        cyc(14);
        apb(0, CTRL, 32'h0);
        chk(what, first - rd_val, 32'h1);
    endtask : step

    task automatic fresh();
        rst <= 1'b1;
        cyc(4);
        rst <= 1'b0;
        cyc(2);
        apb(0, CTRL, 32'h0);
        chk("ctrl reset", rd_val, 32'h7F);
        cyc(30);
        apb(0, CTRL, 32'h0);
        chk("wake hold", rd_val, 32'h7F);
        @(negedge clk);
        chk("active", {31'h0, active}, {31'h0, hwo});
        @(posedge clk);
    endtask : fresh

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, halt, osc_interrupt_enable, hro, hwo, wdl} = '0;
        {osc_irq, ext_irq, paddr, pwdata} = '0;
        n_fail = 0;
        total_checks = 0;
        rst = 1'b1;
        fresh();
        apb(0, 12'h004, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        cyc(240);
        apb(1, CTRL, 32'h42);
        step("tick rate");
        cyc(40);
        look("disabled", 1'b1);
        apb(0, CTRL, 32'h0);
        chk("past 3F", {31'h0, rd_val[6]}, 32'h0);
        apb(1, CTRL, 32'hC1);
        apb(1, CTRL, 32'h41);
        apb(0, CTRL, 32'h0);
        chk("sticky", {24'h0, rd_val[7], 7'h0}, 32'h80);
        wait_fire(60);
        cyc(610);
        look("pulse end", 1'b1);
        $display("test count done");
        fresh();
        cyc(240);
        apb(1, CTRL, 32'h80);
        wait_fire(3);
        fresh();
        cyc(240);
        apb(1, CTRL, 32'hC2);
        rd_val = '0;
        for (i = 0; i < 20 && rd_val[6:0] !== 7'h41; i++)
            apb(0, CTRL, 32'h0);
        pulse_halt();
        cyc(60);
        apb(0, CTRL, 32'h0);
        chk("halt once", rd_val, 32'hC0);
        look("halt quiet", 1'b1);
        apb(0, STAT, 32'h0);
        chk("frozen stat", rd_val,
            32'h1 << `WCR_ST_FROZEN | 32'h1 << `WCR_ST_ACTIVE);
        ext_irq <= 1'b1;
        cyc(1);
        ext_irq <= 1'b0;
        wait_fire(400);
        chk("wake", {31'h0, waited >= 256 && waited <= 280}, 32'h1);
        $display("test halt done");
        fresh();
        cyc(240);
        hro <= 1'b1;
        pulse_halt();
        hro <= 1'b0;
        wait_fire(3);
        fresh();
        cyc(240);
        for (i = 0; i < 2; i++)
        begin
            osc_interrupt_enable <= 1'b1;
            pulse_halt();
            apb(0, CTRL, 32'h0);
            first = rd_val;
            cyc(40);
            apb(0, CTRL, 32'h0);
            chk("stopped", rd_val, first);
            apb(0, STAT, 32'h0);
            chk("halt stat", rd_val, 32'h1 << `WCR_ST_ACT_HALT);
            osc_irq <= (i == 0);
            ext_irq <= (i == 1);
            cyc(1);
            {osc_irq, ext_irq, osc_interrupt_enable} <= 3'b000;
            step("resume");
        end
        osc_interrupt_enable <= 1'b1;
        pulse_halt();
        osc_interrupt_enable <= 1'b0;
        fresh();
        $display("test active halt done");
        hwo <= 1'b1;
        wdl <= 1'b1;
        fresh();
        cyc(300);
        apb(0, CTRL, 32'h0);
        chk("long wake", rd_val, 32'h7F);
        cyc(3800);
        apb(1, CTRL, 32'h41);
        wait_fire(40);
        $display("test hardware option done");
        tally_and_finish();
    end

    initial
    begin
        #1000000;
        n_fail++;
        tally_and_finish();
    end

endmodule : wcr_top_test
